/* File: src/hsm_pkg.sv */
package hsm_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam logic [4:0] DEB_MS = 5'h14;
    localparam logic [7:0] FLASH_MS = 8'hfa;
    localparam logic [7:0] BEEP_MS = 8'hc8;
    localparam int THR_DLY_MAX_S = 15;
    localparam int NEU_DLY_MAX_S = 7;
    localparam logic [15:0] THR_DLY_MAX = 16'(THR_DLY_MAX_S * 1000);
    localparam logic [15:0] NEU_DLY_MAX = 16'(NEU_DLY_MAX_S * 1000);
    localparam logic [15:0] TDLY_RST = 16'h01f4;
    localparam logic [15:0] NDLY_RST = 16'h01f4;
    // Allowed shaft period mismatch, in clock cycles
    localparam logic signed [28:0] SYNC_DB_CYC = 29'sh7d0;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TDLY = 8'h04;
    localparam logic [7:0] REG_NDLY = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_TRIM = 8'h10;
    localparam int CTRL_PRE_EN = 0;
    localparam int CTRL_PRE_LSB = 8;
    localparam int ST_STN = 0;
    localparam int ST_LOCK = 1;
    localparam int ST_OVR = 2;
    localparam int ST_TRL = 3;
    localparam int ST_SYNC = 4;
    localparam int ST_INSYNC = 5;
    localparam int ST_ACK = 6;
    localparam int ST_JAM_LSB = 8;

    // ------------------------------------------------------------
    // Encodings and carriers
    // ------------------------------------------------------------
    localparam logic [1:0] GEAR_N = 2'h0;
    localparam logic [1:0] GEAR_F = 2'h1;
    localparam logic [1:0] GEAR_R = 2'h2;
    localparam logic [7:0] THR_IDLE = 8'h00;
    localparam logic [7:0] TRL_NOSLIP = 8'h00;
    localparam logic [7:0] TRL_MAXSLIP = 8'hff;
    localparam int ENG_P = 0;
    localparam int ENG_S = 1;

    typedef struct packed {
        logic sel;
        logic lock;
        logic ovr;
        logic trl;
        logic syn;
    } hsm_btn_t;
    typedef struct packed {
        logic [1:0] dir;
        logic [7:0] pos;
    } hsm_lever_t;
    typedef struct packed {
        hsm_btn_t btn;
        hsm_lever_t lp;
        hsm_lever_t ls;
    } hsm_head_in_t;
    typedef struct packed {
        logic sel;
        logic lock;
        logic ovr;
        logic trl;
        logic syn;
        logic beep;
    } hsm_head_out_t;
    typedef struct packed {
        logic [1:0] gear;
        logic [7:0] thr;
        logic [7:0] trl;
    } hsm_act_t;
endpackage

/* File: src/hsm_helm.sv */
// How it works
// - Lock press only counts at the commanding station, engaging lockout.
// - Lockout lights the lock lamp and ignores selects from other stations.
// - Second lock press at commanding station releases lockout, lamp off.
// - Override press with both handles neutral enters warm-up override, lamp lit.
// - In override the handle drives throttle only; gear held neutral.
// - Override exit accepted only with handles neutral and a second press.
// - Trolling press drives trolling valve from non-slip to maximum slip.
// - In trolling, lever advance moves valve from maximum toward minimum slip.
// - During trolling the throttle stays idle or at a preset idle.
// - Second trolling press cancels trolling, valve back to non-slip.
// - Synchronize press starts port/starboard shaft speed matching.
// - Sync lamp flashes while matching, steady once within dead band.
// - Compare shaft pulse periods and trim auxiliary throttle to match main.
// - Starboard engine is the main engine; port follows.
// - In sync mode the main handle drives both gears.
// - Sync cannot be entered, and is dropped, while trolling.
// - Station one is the main head, station two the second head.
// - After power-up station one is in command.
// - Throttle delay adjustable, capped at 15 seconds.
// - Neutral (shaft brake) delay adjustable, capped at 7 seconds.
// - After power-up main station beeps and lights select until select press.
// - Jammed or failed actuator gives intermittent beep at commanding station.
// - Select press moves command there, lights its lamp and beeps once.
// - After a jam each select press at the commanding station retries one jammed actuator.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns

// ------------------------------------------------------------
// Button debounce
// ------------------------------------------------------------
module hsm_deb
    import hsm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic raw,
    output logic press
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic st;
        logic [4:0] cnt;
        logic prs;
    } hsm_deb_st_t;
    hsm_deb_st_t q, d;

    // Level must hold DEB_MS ticks before it is believed
    always_comb begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        d.prs = 1'b0;
        if (q.s2 == q.st) begin
            d.cnt = '0;
        end else if (tick) begin
            if (q.cnt == DEB_MS - 5'h01) begin
                d.st = q.s2;
                d.prs = q.s2;
                d.cnt = '0;
            end else begin
                d.cnt = q.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign press = q.prs;
endmodule

// ------------------------------------------------------------
// Helm station mode control
// ------------------------------------------------------------
module hsm_helm
    import hsm_pkg::*;
#(
    parameter int TICK_N = TICK_CYC
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire hsm_head_in_t [1:0] head_in,
    output hsm_head_out_t [1:0] head_out,
    input wire logic [1:0] shaft_pulse,
    input wire logic [3:0] jam_in,
    output logic [3:0] retry,
    output hsm_act_t [1:0] act,
    output logic [1:0] brake
);
    typedef struct packed {
        logic [16:0] div;
        logic tick;
        logic stn;
        logic lock;
        logic ovr;
        logic trl;
        logic syn;
        logic insync;
        logic ack;
        logic [3:0] jam;
        logic [3:0] retry;
        logic [7:0] flash_cnt;
        logic flash;
        logic [7:0] beep_cnt;
        logic pre_en;
        logic [7:0] pre_idle;
        logic [15:0] tdly;
        logic [15:0] ndly;
        logic [1:0][15:0] tcnt;
        logic [1:0][15:0] ncnt;
        logic [1:0] brake;
        logic [1:0][27:0] per;
        logic [1:0][27:0] pcnt;
        logic [1:0] pin;
        logic signed [7:0] trim;
        hsm_act_t [1:0] act;
        hsm_head_out_t [1:0] hout;
        logic [31:0] rdata;
    } hsm_st_t;

    // Trolling valve command 0 is non-slip, so a zero reset is safe
    localparam hsm_st_t ST_RST = '{
        tdly: TDLY_RST, ndly: NDLY_RST, ack: 1'b1, default: '0
    };

    hsm_st_t q, d;
    logic [1:0][4:0] prs;
    hsm_btn_t [1:0] pb;

    // ------------------------------------------------------------
    // Button front end
    // ------------------------------------------------------------
    for (genvar s = 0; s < 2; s++) begin : g_stn
        for (genvar b = 0; b < 5; b++) begin : g_btn
            hsm_deb u_deb (
                .clk(clk),
                .nrst(nrst),
                .tick(q.tick),
                .raw(head_in[s].btn[b]),
                .press(prs[s][b])
            );
        end
    end
    assign pb = prs;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        hsm_btn_t c;
        hsm_lever_t l;
        hsm_lever_t [1:0] lv;
        logic [1:0] g;
        logic [3:0] jsel;
        logic nboth;
        logic signed [28:0] df;
        logic signed [9:0] sum;
        logic [7:0] thr;
        logic [7:0] trl;
        logic on;
        logic [31:0] r;
        c = pb[q.stn];
        lv[ENG_P] = head_in[q.stn].lp;
        lv[ENG_S] = head_in[q.stn].ls;
        l = lv[ENG_S];
        g = GEAR_N;
        jsel = q.jam & (~q.jam + 4'h1);
        nboth = (lv[ENG_P].dir == GEAR_N) && (lv[ENG_S].dir == GEAR_N);
        df = $signed({1'b0, q.per[ENG_P]}) - $signed({1'b0, q.per[ENG_S]});
        sum = '0;
        thr = THR_IDLE;
        trl = TRL_NOSLIP;
        on = 1'b0;
        r = '0;
        d = q;
        d.tick = 1'b0;
        d.retry = '0;

        // Millisecond enable pulse and lamp flash clock
        if (q.div == 17'(TICK_N - 1)) begin
            d.div = '0;
            d.tick = 1'b1;
        end else begin
            d.div = q.div + 17'h1;
        end
        if (q.tick) begin
            if (q.flash_cnt == FLASH_MS - 8'h01) begin
                d.flash_cnt = '0;
                d.flash = ~q.flash;
            end else begin
                d.flash_cnt = q.flash_cnt + 8'h01;
            end
            if (q.beep_cnt != 8'h00) begin
                d.beep_cnt = q.beep_cnt - 8'h01;
            end
        end

        // Select presses: acknowledge, retry a jam or take command
        for (int s = 0; s < 2; s++) begin
            if (pb[s].sel) begin
                if (q.ack) begin
                    if (s == 0) begin
                        d.ack = 1'b0;
                        d.beep_cnt = BEEP_MS;
                    end
                end else if (s == int'(q.stn)) begin
                    d.retry = jsel;
                    d.jam = q.jam & ~jsel;
                end else if (!q.lock) begin
                    d.stn = 1'(s);
                    d.beep_cnt = BEEP_MS;
                end
            end
        end
        // A jam still present beats the retry clear
        d.jam = d.jam | jam_in;

        // Mode buttons act only at the commanding head
        if (!q.ack) begin
            if (c.lock) begin
                d.lock = ~q.lock;
            end
            if (c.ovr && nboth) begin
                d.ovr = ~q.ovr;
            end
            if (c.syn && !q.trl) begin
                d.syn = ~q.syn;
            end
            if (c.trl) begin
                d.trl = ~q.trl;
                if (!q.trl) begin
                    d.syn = 1'b0;
                end
            end
        end

        // Shaft period capture, one pulse per revolution
        for (int e = 0; e < 2; e++) begin
            d.pin[e] = shaft_pulse[e];
            if (shaft_pulse[e] && !q.pin[e]) begin
                d.per[e] = q.pcnt[e];
                d.pcnt[e] = '0;
            end else if (q.pcnt[e] != '1) begin
                d.pcnt[e] = q.pcnt[e] + 28'h1;
            end
        end

        // Port trim chases starboard; a longer period means slower
        if (!q.syn) begin
            d.trim = '0;
            d.insync = 1'b0;
        end else if (q.tick) begin
            d.insync = (df <= SYNC_DB_CYC) && (df >= -SYNC_DB_CYC);
            if (df > SYNC_DB_CYC && q.trim != 8'sh7f) begin
                d.trim = q.trim + 8'sh01;
            end else if (df < -SYNC_DB_CYC && q.trim != -8'sh80) begin
                d.trim = q.trim - 8'sh01;
            end
        end

        // Per-engine gear, delays and actuator commands
        for (int e = 0; e < 2; e++) begin
            l = q.syn ? lv[ENG_S] : lv[e];
            g = (q.ack || q.ovr) ? GEAR_N : l.dir;
            thr = q.ack ? THR_IDLE : l.pos;
            trl = TRL_NOSLIP;
            if (q.trl) begin
                trl = TRL_MAXSLIP - l.pos;
                thr = q.pre_en ? q.pre_idle : THR_IDLE;
            end else if (q.syn && e == ENG_P) begin
                // Signed trim is clamped at the throttle ends rather than wrapped
                sum = $signed({2'b00, thr}) + $signed({{2{q.trim[7]}}, q.trim});
                if (sum < 10'sh000) begin
                    thr = THR_IDLE;
                end else if (sum > 10'sh0ff) begin
                    thr = 8'hff;
                end else begin
                    thr = sum[7:0];
                end
            end
            // A gear change restarts both delays; the throttle waits at idle until the throttle delay runs out
            if (g != q.act[e].gear) begin
                d.tcnt[e] = q.tdly;
                d.ncnt[e] = q.ndly;
            end else if (q.tick) begin
                if (q.tcnt[e] != 16'h0000) begin
                    d.tcnt[e] = q.tcnt[e] - 16'h0001;
                end
                if (q.ncnt[e] != 16'h0000) begin
                    d.ncnt[e] = q.ncnt[e] - 16'h0001;
                end
            end
            if (q.tcnt[e] != 16'h0000) begin
                thr = THR_IDLE;
            end
            d.brake[e] = (g == GEAR_N) && (q.ncnt[e] == 16'h0000);
            d.act[e].gear = g;
            d.act[e].thr = thr;
            d.act[e].trl = trl;
        end
        // Lamps and horn only at the head in command; station one is index 0
        for (int s = 0; s < 2; s++) begin
            on = (s == int'(q.stn));
            d.hout[s].sel = on;
            d.hout[s].lock = on && q.lock;
            d.hout[s].ovr = on && q.ovr;
            d.hout[s].trl = on && q.trl;
            d.hout[s].syn = on && q.syn && (q.insync || q.flash);
            d.hout[s].beep = on && (q.ack || q.beep_cnt != 8'h00 || (|q.jam && q.flash));
        end

        // Register writes; delay settings saturate at their ceilings
        if (wr) begin
            case (addr)
                REG_CTRL: begin
                    d.pre_en = wdata[CTRL_PRE_EN];
                    d.pre_idle = wdata[CTRL_PRE_LSB +: 8];
                end
                REG_TDLY: d.tdly = (wdata > 32'(THR_DLY_MAX)) ? THR_DLY_MAX : wdata[15:0];
                REG_NDLY: d.ndly = (wdata > 32'(NEU_DLY_MAX)) ? NEU_DLY_MAX : wdata[15:0];
                default: ;
            endcase
        end
        // Read data stand only in the cycle after the strobe; zero otherwise
        if (rd) begin
            case (addr)
                REG_CTRL: begin
                    r[CTRL_PRE_EN] = q.pre_en;
                    r[CTRL_PRE_LSB +: 8] = q.pre_idle;
                end
                REG_TDLY: r[15:0] = q.tdly;
                REG_NDLY: r[15:0] = q.ndly;
                REG_STAT: begin
                    r[ST_STN] = q.stn;
                    r[ST_LOCK] = q.lock;
                    r[ST_OVR] = q.ovr;
                    r[ST_TRL] = q.trl;
                    r[ST_SYNC] = q.syn;
                    r[ST_INSYNC] = q.insync;
                    r[ST_ACK] = ~q.ack; // Reads one once control is acknowledged
                    r[ST_JAM_LSB +: 4] = q.jam;
                end
                REG_TRIM: r = {{24{q.trim[7]}}, q.trim};
                default: r = '0;
            endcase
        end
        d.rdata = r;
    end

    // ------------------------------------------------------------
    // State register and outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // Every output is a flop of the state, so no decode glitch reaches a pin
    assign rdata = q.rdata;
    assign head_out = q.hout;
    assign act = q.act;
    assign brake = q.brake;
    assign retry = q.retry;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ovr_gear: assert property (@(posedge clk) disable iff (!nrst) q.ovr |=>
        {q.act[ENG_P].gear, q.act[ENG_S].gear} == {GEAR_N, GEAR_N}) else $error("gear moved");
    chk_trl_no_sync: assert property (@(posedge clk) disable iff (!nrst)
        !(q.trl && q.syn)) else $error("sync active in trolling");
    chk_lock_keeps_stn: assert property (@(posedge clk) disable iff (!nrst)
        q.lock |=> $stable(q.stn)) else $error("station changed while locked");
    chk_ack_beeps: assert property (@(posedge clk) disable iff (!nrst)
        q.ack |=> q.hout[0].beep && q.hout[0].sel) else $error("power-up call missing");
    chk_retry_single: assert property (@(posedge clk) disable iff (!nrst)
        $onehot0(q.retry)) else $error("more than one retry at once");
    chk_dly_capped: assert property (@(posedge clk) disable iff (!nrst)
        q.tdly <= THR_DLY_MAX && q.ndly <= NEU_DLY_MAX) else $error("delay above ceiling");
endmodule

/* File: verif/hsm_far.sv */
`timescale 1ns/1ns

// ------------------------------------------------------------
// Far side: two control heads and the shaft pickups
// ------------------------------------------------------------
module hsm_far
    import hsm_pkg::*;
(
    input wire logic clk,
    input wire logic [1:0] stn,
    input wire hsm_btn_t btn,
    input wire hsm_lever_t lever,
    output hsm_head_in_t [1:0] head_in,
    output logic [1:0] shaft_pulse
);
    logic [9:0] cnt = '0;

    // Head address n sits at index n-1; the operator moves both handles together
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            head_in[i].btn = (stn == 2'(i + 1)) ? btn : '0;
            head_in[i].lp = lever;
            head_in[i].ls = lever;
        end
    end

    // One pulse per revolution; equal speeds keep the matcher quiet
    always_ff @(posedge clk) begin
        cnt <= cnt + 10'h1;
    end
    assign shaft_pulse = {2{cnt < 10'h4}};
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ns

module tb_top;
    import hsm_pkg::*;
    localparam int TICK = 4;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [1:0] stn = 2'h0;
    hsm_btn_t btn = '0;
    hsm_lever_t lever = '0;
    logic [3:0] jam_in = '0;
    hsm_head_in_t [1:0] head_in;
    hsm_head_out_t [1:0] head_out;
    logic [1:0] shaft_pulse;
    hsm_act_t [1:0] act;
    logic [1:0] brake;
    logic [3:0] retry;
    logic [3:0] retry_seen = '0;
    logic [31:0] rv;
    int error_cnt = 0;
    int n_compared = 0;

    // ------------------------------------------------------------
    // Clock, design and far side
    // ------------------------------------------------------------
    always #5 clk = ~clk;

    hsm_helm #(.TICK_N(TICK)) hsm_helm_i (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .head_in(head_in),
        .head_out(head_out), .shaft_pulse(shaft_pulse), .jam_in(jam_in),
        .retry(retry), .act(act), .brake(brake));
    hsm_far hsm_far_i (.clk(clk), .stn(stn), .btn(btn), .lever(lever),
        .head_in(head_in), .shaft_pulse(shaft_pulse));

    // Retry is a one-cycle pulse; keep the last one for the scenario to judge
    always @(posedge clk) begin
        if (retry != 4'h0) begin
            retry_seen <= retry;
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Held well past the debounce span, then released as long
    task automatic press(input logic [1:0] s, input hsm_btn_t b);
        @(posedge clk);
        stn <= s;
        btn <= b;
        repeat (40 * TICK) @(posedge clk);
        btn <= '0;
        repeat (40 * TICK) @(posedge clk);
    endtask

    task automatic settle;
        repeat (2000) @(posedge clk);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power;
        check("sel lamp 1", 1, head_out[0].sel);
        check("sel lamp 2", 0, head_out[1].sel);
        check("power beep", 1, head_out[0].beep);
        reg_rd(REG_STAT, rv);
        check("ack before", 0, rv[ST_ACK]);
        press(2'h1, 5'h10);
        reg_rd(REG_STAT, rv);
        check("ack after", 1, rv[ST_ACK]);
    endtask

    task automatic t_lock;
        press(2'h2, 5'h08);
        check("lock idle stn", 0, head_out[0].lock);
        press(2'h1, 5'h08);
        check("lock on", 1, head_out[0].lock);
        press(2'h2, 5'h10);
        check("locked sel 2", 0, head_out[1].sel);
        check("locked sel 1", 1, head_out[0].sel);
        press(2'h1, 5'h08);
        check("lock off", 0, head_out[0].lock);
        press(2'h2, 5'h10);
        check("take sel 2", 1, head_out[1].sel);
        check("drop sel 1", 0, head_out[0].sel);
        press(2'h1, 5'h10);
    endtask

    task automatic t_ovr;
        press(2'h1, 5'h04);
        check("ovr on", 1, head_out[0].ovr);
        lever <= '{GEAR_F, 8'h80};
        settle();
        check("ovr gear p", GEAR_N, act[ENG_P].gear);
        check("ovr gear s", GEAR_N, act[ENG_S].gear);
        check("ovr thr", 8'h80, act[ENG_P].thr);
        check("ovr brake", 2'h3, brake);
        press(2'h1, 5'h04);
        check("ovr stays", 1, head_out[0].ovr);
        lever <= '0;
        press(2'h1, 5'h04);
        check("ovr off", 0, head_out[0].ovr);
    endtask

    task automatic t_trl;
        press(2'h1, 5'h02);
        settle();
        check("trl max slip", TRL_MAXSLIP, act[ENG_P].trl);
        lever <= '{GEAR_F, 8'hff};
        settle();
        check("trl toward min", 1, act[ENG_P].trl < TRL_MAXSLIP);
        check("trl thr idle", THR_IDLE, act[ENG_P].thr);
        press(2'h1, 5'h01);
        check("no sync in trl", 0, head_out[0].syn);
        lever <= '0;
        press(2'h1, 5'h02);
        settle();
        check("trl no slip", TRL_NOSLIP, act[ENG_P].trl);
        press(2'h1, 5'h01);
        reg_rd(REG_STAT, rv);
        check("sync on", 1, rv[ST_SYNC]);
        settle();
        check("sync steady", 1, head_out[0].syn);
    endtask

    // Two jams at once: intermittent horn, then one retry per select press
    task automatic t_jam;
        logic hi;
        logic lo;
        hi = 1'b0;
        lo = 1'b0;
        jam_in <= 4'h6;
        @(posedge clk);
        jam_in <= 4'h0;
        repeat (3000) begin
            @(negedge clk);
            hi |= head_out[0].beep;
            lo |= ~head_out[0].beep;
        end
        check("jam beep on", 1, hi);
        check("jam beep off", 1, lo);
        press(2'h1, 5'h10);
        check("retry first", 4'h2, retry_seen);
        press(2'h1, 5'h10);
        check("retry second", 4'h4, retry_seen);
    endtask

    task automatic t_regs;
        reg_wr(REG_TDLY, 32'hffff);
        reg_wr(REG_NDLY, 32'hffff);
        reg_rd(REG_TDLY, rv);
        check("thr dly cap", 32'(THR_DLY_MAX), rv);
        reg_rd(REG_NDLY, rv);
        check("neu dly cap", 32'(NEU_DLY_MAX), rv);
        reg_wr(REG_CTRL, 32'h2001);
        reg_rd(REG_CTRL, rv);
        check("preset idle", 32'h2001, rv);
        reg_rd(8'hfc, rv);
        check("unmapped", 32'h0, rv);
    endtask

    // ------------------------------------------------------------
    // Run and verdict
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Delays zeroed after the power-up check so actuator moves do not stretch the run
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_power();
        reg_wr(REG_TDLY, 32'h0);
        reg_wr(REG_NDLY, 32'h0);
        t_lock();
        t_ovr();
        t_trl();
        t_jam();
        t_regs();
        end_sim();
    end

    // Watchdog well beyond the expected span of about 20000 cycles
    initial begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] watchdog expected done seen hang");
        end_sim();
    end
endmodule
